// ==== core/apust_pkg.sv ====
// Purpose: shared constants of the arithmetic unit host port
// Assumes: MCLK runs at 40 MHz
// Notes: command codes index the two latency tables
package apust_pkg;

	// ==========================================================
	// Clock and host timing
	localparam int CLK_NS = 25;
	localparam int READ_DATA_TCY10 = 35;
	localparam int READ_STAT_TCY10 = 15;
	localparam int READ_MARGIN_NS = 50;
	localparam int WRITE_READY_LOW_WIDTH_NS = 50;
	localparam int CMD_RECOV_TCY = 4;
	localparam int DATA_RECOV_TCY = 5;
	localparam int END_PULSE_NS = 200;
	// Least times round up, the write stall stays strictly below its limit
	localparam int RD_DATA_CYC = (READ_DATA_TCY10 * CLK_NS + 10 * READ_MARGIN_NS + 10 * CLK_NS - 1) / (10 * CLK_NS);
	localparam int RD_STAT_CYC = (READ_STAT_TCY10 * CLK_NS + 10 * READ_MARGIN_NS + 10 * CLK_NS - 1) / (10 * CLK_NS);
	localparam int WR_READY_RAW = (WRITE_READY_LOW_WIDTH_NS - 1) / CLK_NS;
	localparam int WR_READY_CYC = (WR_READY_RAW < 1) ? 1 : WR_READY_RAW;
	localparam int END_PULSE_CYC = (END_PULSE_NS + CLK_NS - 1) / CLK_NS;

	// ==========================================================
	// Pins, status and command fields
	localparam logic [13:0] PIN_RST = 14'h3f00;
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [7:0] BUS_RST = 8'h00;
	localparam int CMD_SVC_BIT = 7;
	localparam int ST_BUSY = 7;
	localparam logic [3:0] ERR_NONE = 4'h0;
	localparam logic [3:0] ERR_DIV0 = 4'h8;
	localparam logic [3:0] ERR_NEG = 4'h4;
	localparam logic [3:0] ERR_ARG = 4'hc;
	localparam logic [3:0] ERR_UNDER = 4'h2;
	localparam logic [3:0] ERR_OVER = 4'h1;
	localparam logic [23:0] MANT_HALF = 24'h800000;

	// ==========================================================
	// Commands, in table order
	typedef enum logic [5:0] {
		CMD_FIX16_ADD, CMD_FIX16_SUB, CMD_FIX16_MUL_LOW, CMD_FIX16_MUL_HIGH, CMD_FIX16_DIV,
		CMD_FIX32_ADD, CMD_FIX32_SUB, CMD_FIX32_MUL_LOW, CMD_FIX32_MUL_HIGH, CMD_FIX32_DIV,
		CMD_FLOAT_ADD, CMD_FLOAT_SUB, CMD_FLOAT_MUL, CMD_FLOAT_DIV,
		CMD_FLOAT_TO_FIX16, CMD_FLOAT_TO_FIX32, CMD_FIX16_TO_FLOAT, CMD_FIX32_TO_FLOAT,
		CMD_SQUARE_ROOT_OP, CMD_SINE_OP, CMD_COSINE_OP, CMD_TANGENT_OP,
		CMD_ARCSINE_OP, CMD_ARCCOSINE_OP, CMD_ARCTANGENT_OP,
		CMD_NATURAL_LOG_OP, CMD_COMMON_LOG_OP, CMD_EXPONENTIAL_OP, CMD_POWER_OP,
		CMD_NO_OPERATION, CMD_NEGATE_FIX16, CMD_NEGATE_FIX32, CMD_NEGATE_FLOAT,
		CMD_PUSH_COPY_FIX16, CMD_PUSH_COPY_FIX32, CMD_PUSH_COPY_FLOAT,
		CMD_POP_FIX16, CMD_POP_FIX32, CMD_POP_FLOAT,
		CMD_SWAP_FIX16, CMD_SWAP_FIX32, CMD_SWAP_FLOAT
	} apust_cmd_type;
	localparam logic [5:0] CMD_COUNT = 6'h2a;

	// ==========================================================
	// Execution cycles per command, least and most
	localparam int EXEC_W = 14;
	localparam logic [13:0] LAT_MIN [42] = '{
		14'd17, 14'd30, 14'd84, 14'd80, 14'd84, 14'd21, 14'd38, 14'd194, 14'd182, 14'd208,
		14'd54, 14'd70, 14'd146, 14'd154, 14'd92, 14'd100, 14'd98, 14'd98,
		14'd800, 14'd4464, 14'd4118, 14'd5754, 14'd7668, 14'd7734, 14'd6006,
		14'd4298, 14'd4474, 14'd3794, 14'd8290, 14'd4, 14'd23, 14'd27, 14'd18,
		14'd16, 14'd20, 14'd20, 14'd10, 14'd12, 14'd12, 14'd18, 14'd26, 14'd26};
	localparam logic [13:0] LAT_MAX [42] = '{
		14'd17, 14'd30, 14'd94, 14'd98, 14'd94, 14'd21, 14'd38, 14'd210, 14'd218, 14'd208,
		14'd368, 14'd370, 14'd168, 14'd184, 14'd216, 14'd346, 14'd186, 14'd378,
		14'd800, 14'd4464, 14'd4118, 14'd5754, 14'd7668, 14'd7734, 14'd6006,
		14'd6956, 14'd7132, 14'd4878, 14'd12032, 14'd4, 14'd23, 14'd27, 14'd18,
		14'd16, 14'd20, 14'd20, 14'd10, 14'd12, 14'd12, 14'd18, 14'd26, 14'd26};

endpackage

// ==== core/apust_timer.sv ====
// Purpose: loadable down counter used for every wait in the port
// Assumes: synchronous active-low reset, shared clock enable
// Notes: idle is high while the count stands at zero
`timescale 1ns/10ps
`default_nettype none

module apust_timer #(
	parameter int W = 4
) (
	// Clock and control
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Load and state
	input wire logic load,
	input wire logic [W-1:0] value,
	output logic idle
);

	logic [W-1:0] cnt_q;

	// ==========================================================
	// Count down to zero, a load wins over counting
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_q <= '0;
		end else if (ce) begin
			if (load) begin
				cnt_q <= value;
			end else if (!idle) begin
				cnt_q <= cnt_q - W'(1);
			end
		end
	end

	assign idle = (cnt_q == '0);

endmodule
`default_nettype wire

// ==== core/apust_core.sv ====
// Purpose: host port, status register and command timing of a stack arithmetic unit
// Assumes: host pins are asynchronous to MCLK; 40 MHz clock
// Notes: 16-bit add, subtract, negate, copy and every pop change the stack; the rest only time and flag
//
// Summary of operation
// - While busy, status reads show only the busy bit as meaningful.
// - A status read drives the status byte onto the data bus.
// - 32-bit fixed add, subtract, multiply and divide take their listed cycles.
// - Float add, subtract, multiply and divide take their listed cycles.
// - Square root and trigonometric commands take their listed cycles.
// - Log, exponential and power commands take their listed cycles.
// - Format conversions take their listed cycles.
// - Push copy and pop commands take their listed cycles.
// - No-operation, swap and negate take their listed cycles.
// - Counts are clock cycles; ranged counts depend on operand data.
// - Common log is natural log times a fixed factor.
// - Power is exponential of y times natural log of x.
// - Derived results keep small relative or absolute error.
// - Every command completion is signalled on the done output.
// - Reads hold ready low a least time, data reads also until execution ends.
// - Idle writes to either port drop ready for under 50 ns.
// - Done pulses briefly if acknowledge tied low, else waits for acknowledge.
// - Done falls and busy clears in the same cycle.
// - Completion raises service request if enabled; service acknowledge clears it.
// - Error field codes divide by zero, negative argument, large argument, range.
`timescale 1ns/10ps
`default_nettype none

module apust_core
	import apust_pkg::*;
(
	// Clock, reset and enable
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic CE,
	// Host bus strobes
	input wire logic CS_N,
	input wire logic CMD_DATA_SELECT,
	input wire logic RD_N,
	input wire logic WR_N,
	// Host data bus, split
	input wire logic [7:0] DB_I,
	output logic [7:0] DB_O,
	output logic DB_OE,
	// Handshakes
	output logic READY,
	output logic EXEC_DONE_N,
	input wire logic EXEC_DONE_ACK_N,
	output logic SERVICE_REQUEST,
	input wire logic SERVICE_ACK_N
);

	typedef enum logic [1:0] {S_IDLE, S_WAIT, S_HOLD} apust_state_type;

	// ==========================================================
	// Pin synchronisers
	logic [13:0] meta_q;
	logic [13:0] pin_q;

	// Two flops per pin input, the first read only by the second
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			meta_q <= PIN_RST;
			pin_q <= PIN_RST;
		end else if (CE) begin
			meta_q <= {CS_N, CMD_DATA_SELECT, RD_N, WR_N, EXEC_DONE_ACK_N, SERVICE_ACK_N, DB_I};
			pin_q <= meta_q;
		end
	end

	wire logic sel_cmd = pin_q[12];
	wire logic rd_act = !pin_q[13] && !pin_q[11];
	wire logic wr_act = !pin_q[13] && !pin_q[10];
	wire logic exec_done_ack_n_n_s = pin_q[9];
	wire logic service_ack_n_n_s = pin_q[8];
	wire logic [7:0] db_s = pin_q[7:0];

	// ==========================================================
	// Declarations
	apust_state_type st_q;
	apust_state_type st_d;
	apust_cmd_type cmd_q;
	logic acc_rd_q;
	logic acc_cmd_q;
	logic busy_q;
	logic svc_en_q;
	logic [3:0] err_q;
	logic carry_q;
	logic [7:0] wdat_q;
	logic [7:0] out_q;
	logic oe_q;
	logic end_low_q;
	logic ack_tied_q;
	logic svc_q;
	logic exec_done_ack_n_prev_q;
	logic service_ack_n_prev_q;
	logic [3:0] ptr_q;
	logic [7:0] stk_q [16];
	logic rdy_idle;
	logic rec_idle;
	logic exec_idle;
	logic end_idle;
	logic [15:0] res16;
	logic [3:0] res_addr;
	logic res_we;
	logic [3:0] ptr_fin;
	logic [3:0] err_fin;
	logic carry_fin;

	// ==========================================================
	// Access sequencing
	wire logic start = (st_q == S_IDLE) && (rd_act || wr_act);
	wire logic start_rd = rd_act;
	// Status reads pass a busy unit, other accesses wait for completion
	wire logic blocked = busy_q && !(acc_rd_q && acc_cmd_q);
	// Writes also wait out the recovery time of the previous write
	wire logic wait_done = (st_q == S_WAIT) && rdy_idle && !blocked && (acc_rd_q || rec_idle);
	wire logic release_acc = (st_q == S_HOLD) && !rd_act && !wr_act;
	wire logic commit_wr = release_acc && !acc_rd_q;
	wire logic push_now = commit_wr && !acc_cmd_q;
	wire logic cmd_now = commit_wr && acc_cmd_q;
	wire logic pop_now = wait_done && acc_rd_q && !acc_cmd_q;
	wire logic fin = busy_q && exec_idle;

	// Ready low time chosen by access kind
	wire logic [3:0] rdy_load = start_rd ? (sel_cmd ? 4'(RD_STAT_CYC - 1) : 4'(RD_DATA_CYC - 1))
		: 4'(WR_READY_CYC - 1);
	wire logic [3:0] rec_load = acc_cmd_q ? 4'(CMD_RECOV_TCY - 1) : 4'(DATA_RECOV_TCY - 1);

	// Next access state
	always_comb begin
		st_d = st_q;
		case (st_q)
			S_IDLE: begin
				if (start) begin
					st_d = S_WAIT;
				end
			end
			S_WAIT: begin
				if (wait_done) begin
					st_d = S_HOLD;
				end
			end
			S_HOLD: begin
				if (release_acc) begin
					st_d = S_IDLE;
				end
			end
			default: begin
				st_d = S_IDLE;
			end
		endcase
	end

	// Access state and kind
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			st_q <= S_IDLE;
			acc_rd_q <= 1'b0;
			acc_cmd_q <= 1'b0;
		end else if (CE) begin
			st_q <= st_d;
			if (start) begin
				acc_rd_q <= start_rd;
				acc_cmd_q <= sel_cmd;
			end
		end
	end

	// Ready and write recovery timers
	apust_timer #(.W(4)) u_rdy (
		.clk(MCLK),
		.rst_n(RST_N),
		.ce(CE),
		.load(start),
		.value(rdy_load),
		.idle(rdy_idle)
	);

	apust_timer #(.W(4)) u_rec (
		.clk(MCLK),
		.rst_n(RST_N),
		.ce(CE),
		.load(commit_wr),
		.value(rec_load),
		.idle(rec_idle)
	);

	// ==========================================================
	// Stack and status view
	wire logic [3:0] p1 = ptr_q - 4'h1;
	wire logic [3:0] p2 = ptr_q - 4'h2;
	wire logic [3:0] p3 = ptr_q - 4'h3;
	wire logic [3:0] n2 = ptr_q + 4'h2;
	wire logic [15:0] tos16 = {stk_q[ptr_q], stk_q[p1]};
	wire logic [15:0] nos16 = {stk_q[p2], stk_q[p3]};
	wire logic tos32_zero = (tos16 == 16'h0000) && (nos16 == 16'h0000);
	wire logic [6:0] tos_exp = stk_q[ptr_q][6:0];
	wire logic [23:0] tos_mant = {stk_q[p1], nos16};
	wire logic tos_neg = stk_q[ptr_q][7];
	// Float magnitude above one
	wire logic arg_big = !tos_exp[6] && ((tos_exp > 7'h01) || ((tos_exp == 7'h01) && (tos_mant != MANT_HALF)));
	wire logic [7:0] status_full = {1'b0, tos_neg, tos16 == 16'h0000, err_q, carry_q};
	// Flags other than busy are hidden while executing
	wire logic [7:0] status_view = busy_q ? (8'h01 << ST_BUSY) : status_full;
	wire logic [3:0] ptr_d = push_now ? ptr_q + 4'h1 : pop_now ? p1 : fin ? ptr_fin : ptr_q;

	// Stack bytes, kept across reset
	always_ff @(posedge MCLK) begin
		if (CE) begin
			if (push_now) begin
				stk_q[ptr_d] <= wdat_q;
			end else if (fin && res_we) begin
				stk_q[res_addr] <= res16[15:8];
				stk_q[res_addr - 4'h1] <= res16[7:0];
			end
		end
	end

	// ==========================================================
	// Command results and error codes
	wire logic [16:0] sum17 = {1'b0, nos16} + {1'b0, tos16};
	wire logic [16:0] dif17 = {1'b0, nos16} - {1'b0, tos16};
	wire logic add_ovf = (nos16[15] == tos16[15]) && (sum17[15] != nos16[15]);
	wire logic sub_ovf = (nos16[15] != tos16[15]) && (dif17[15] != nos16[15]);

	// Result of the finishing command
	always_comb begin
		res16 = tos16;
		res_addr = ptr_q;
		res_we = 1'b0;
		ptr_fin = ptr_q;
		err_fin = ERR_NONE;
		carry_fin = 1'b0;
		case (cmd_q)
			CMD_FIX16_ADD: begin
				res16 = sum17[15:0];
				res_addr = p2;
				res_we = 1'b1;
				ptr_fin = p2;
				carry_fin = sum17[16];
				err_fin = add_ovf ? ERR_OVER : ERR_NONE;
			end
			CMD_FIX16_SUB: begin
				res16 = dif17[15:0];
				res_addr = p2;
				res_we = 1'b1;
				ptr_fin = p2;
				carry_fin = dif17[16];
				err_fin = sub_ovf ? ERR_OVER : ERR_NONE;
			end
			CMD_NEGATE_FIX16: begin
				res16 = 16'h0000 - tos16;
				res_we = 1'b1;
				err_fin = (tos16 == 16'h8000) ? ERR_OVER : ERR_NONE;
			end
			CMD_PUSH_COPY_FIX16: begin
				res_addr = n2;
				res_we = 1'b1;
				ptr_fin = n2;
			end
			CMD_FIX16_DIV: begin
				err_fin = (tos16 == 16'h0000) ? ERR_DIV0 : ERR_NONE;
			end
			CMD_FIX32_DIV, CMD_FLOAT_DIV: begin
				err_fin = tos32_zero ? ERR_DIV0 : ERR_NONE;
			end
			CMD_SQUARE_ROOT_OP, CMD_NATURAL_LOG_OP, CMD_COMMON_LOG_OP, CMD_POWER_OP: begin
				err_fin = tos_neg ? ERR_NEG : ERR_NONE;
			end
			CMD_ARCSINE_OP, CMD_ARCCOSINE_OP: begin
				err_fin = arg_big ? ERR_ARG : ERR_NONE;
			end
			CMD_POP_FIX16: begin
				ptr_fin = p2;
			end
			CMD_POP_FIX32, CMD_POP_FLOAT: begin
				ptr_fin = ptr_q - 4'h4;
			end
			default: begin
				err_fin = ERR_NONE;
			end
		endcase
	end

	// ==========================================================
	// Command latency
	wire logic [5:0] new_code = (wdat_q[5:0] < CMD_COUNT) ? wdat_q[5:0] : 6'(CMD_NO_OPERATION);
	wire logic [13:0] lat_min = LAT_MIN[new_code];
	wire logic [13:0] lat_span = LAT_MAX[new_code] - lat_min;
	// Operand byte places a ranged count between its limits
	wire logic [21:0] lat_scaled = lat_span * stk_q[ptr_q];
	wire logic [13:0] lat_cyc = lat_min + lat_scaled[21:8];
	wire logic [13:0] exec_load = lat_cyc - 14'h0001;

	apust_timer #(.W(EXEC_W)) u_exec (
		.clk(MCLK),
		.rst_n(RST_N),
		.ce(CE),
		.load(cmd_now),
		.value(exec_load),
		.idle(exec_idle)
	);

	// Busy, command and result status
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			busy_q <= 1'b0;
			cmd_q <= CMD_NO_OPERATION;
			svc_en_q <= 1'b0;
			{err_q, carry_q} <= STATUS_RST[4:0];
			ptr_q <= 4'h0;
		end else if (CE) begin
			ptr_q <= ptr_d;
			if (cmd_now) begin
				busy_q <= 1'b1;
				cmd_q <= apust_cmd_type'(new_code);
				svc_en_q <= wdat_q[CMD_SVC_BIT];
			end else if (fin) begin
				busy_q <= 1'b0;
				err_q <= err_fin;
				carry_q <= carry_fin;
			end
		end
	end

	// ==========================================================
	// Host data path
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			wdat_q <= BUS_RST;
			out_q <= BUS_RST;
			oe_q <= 1'b0;
		end else if (CE) begin
			if ((st_q == S_HOLD) && wr_act) begin
				wdat_q <= db_s;
			end
			if (wait_done && acc_rd_q) begin
				out_q <= acc_cmd_q ? status_view : stk_q[ptr_q];
			end
			oe_q <= (st_d == S_HOLD) && acc_rd_q;
		end
	end

	// ==========================================================
	// Done and service request
	wire logic exec_done_ack_n_fall = exec_done_ack_n_prev_q && !exec_done_ack_n_n_s;
	wire logic service_ack_n_fall = service_ack_n_prev_q && !service_ack_n_n_s;
	wire logic end_release = ack_tied_q ? end_idle : exec_done_ack_n_fall;

	apust_timer #(.W(4)) u_end (
		.clk(MCLK),
		.rst_n(RST_N),
		.ce(CE),
		.load(fin),
		.value(4'(END_PULSE_CYC)),
		.idle(end_idle)
	);

	// Completion sets win over acknowledges in the same cycle
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			end_low_q <= 1'b0;
			ack_tied_q <= 1'b0;
			svc_q <= 1'b0;
			exec_done_ack_n_prev_q <= 1'b1;
			service_ack_n_prev_q <= 1'b1;
		end else if (CE) begin
			exec_done_ack_n_prev_q <= exec_done_ack_n_n_s;
			service_ack_n_prev_q <= service_ack_n_n_s;
			if (fin) begin
				end_low_q <= 1'b1;
				ack_tied_q <= !exec_done_ack_n_n_s;
			end else if (end_release) begin
				end_low_q <= 1'b0;
			end
			if (fin && svc_en_q) begin
				svc_q <= 1'b1;
			end else if (service_ack_n_fall) begin
				svc_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Outputs
	assign READY = (st_q != S_WAIT);
	assign EXEC_DONE_N = !end_low_q;
	assign SERVICE_REQUEST = svc_q;
	assign DB_O = out_q;
	assign DB_OE = oe_q;

endmodule
`default_nettype wire

// ==== tb/apust_chk.sv ====
// Purpose: port checker of the arithmetic unit host port
// Assumes: one clock, synchronous active-low reset
// Notes: sees only core ports, bound after the module
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Port checker
module apust_chk (
	// Clock and reset
	input wire logic MCLK,
	input wire logic RST_N,
	// Host pins
	input wire logic CS_N,
	input wire logic RD_N,
	input wire logic WR_N,
	input wire logic DB_OE,
	input wire logic READY,
	// Handshakes
	input wire logic EXEC_DONE_N,
	input wire logic EXEC_DONE_ACK_N,
	input wire logic SERVICE_REQUEST,
	input wire logic SERVICE_ACK_N
);
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	// Bus timing
	chk_ready_on_access: assert property ($fell(READY) |-> !$past(CS_N, 2) && !($past(RD_N, 2) && $past(WR_N, 2)))
		else $error("ready fell without an access");
	chk_oe_with_ready: assert property ($rose(DB_OE) |-> $rose(READY))
		else $error("bus driven before ready");
	chk_oe_on_read: assert property (DB_OE |-> !$past(RD_N, 1) || !$past(RD_N, 2) || !$past(RD_N, 3) || !$past(RD_N, 4))
		else $error("bus driven without a read");
	chk_oe_release: assert property ($fell(DB_OE) |-> $past(RD_N, 2) || $past(CS_N, 2))
		else $error("bus released while read held");
	// Done and service request; the fixed width applies only with acknowledge held low at completion
	chk_done_width: assert property ($fell(EXEC_DONE_N) && !EXEC_DONE_ACK_N && !$past(EXEC_DONE_ACK_N)
		&& !$past(EXEC_DONE_ACK_N, 2) && !$past(EXEC_DONE_ACK_N, 3) |=> !EXEC_DONE_N [*8])
		else $error("done pulse too short");
	chk_done_release: assert property ($rose(EXEC_DONE_N) |-> !$past(EXEC_DONE_ACK_N, 2) || !$past(EXEC_DONE_ACK_N, 3)
		|| !$past(EXEC_DONE_ACK_N, 4) || !$past(EXEC_DONE_ACK_N, 5))
		else $error("done released without acknowledge");
	chk_svc_with_done: assert property ($rose(SERVICE_REQUEST) |-> $fell(EXEC_DONE_N))
		else $error("service request apart from done");
	chk_svc_holds: assert property (SERVICE_REQUEST && SERVICE_ACK_N && $past(SERVICE_ACK_N) && $past(SERVICE_ACK_N, 2)
		|=> SERVICE_REQUEST)
		else $error("service request dropped unasked");
endmodule
bind apust_core apust_chk chk_u (.MCLK(MCLK), .RST_N(RST_N), .CS_N(CS_N), .RD_N(RD_N), .WR_N(WR_N), .DB_OE(DB_OE),
	.READY(READY), .EXEC_DONE_N(EXEC_DONE_N), .EXEC_DONE_ACK_N(EXEC_DONE_ACK_N),
	.SERVICE_REQUEST(SERVICE_REQUEST), .SERVICE_ACK_N(SERVICE_ACK_N));
`default_nettype wire

// ==== tb/apust_host.sv ====
// Purpose: host model driving the arithmetic unit bus
// Assumes: strobes move on the falling clock edge
// Notes: released data lines show the inverse of the last byte
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Host bus master
module apust_host (
	// Clock and answers
	input wire logic mclk,
	input wire logic ready,
	input wire logic [7:0] db_o,
	// Strobes and data
	output logic cs_n,
	output logic sel,
	output logic rd_n,
	output logic wr_n,
	output logic [7:0] db_i,
	// Acknowledges
	output logic done_ack_n,
	output logic svc_ack_n
);
	// Idle bus at time zero
	initial begin
		cs_n = 1'b1;
		sel = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
		db_i = 8'h00;
		done_ack_n = 1'b1;
		svc_ack_n = 1'b1;
	end
	// One access held until ready is sampled high
	task automatic xfer(input logic rd, input logic cmd, input logic [7:0] wd, input int gap,
		output logic [7:0] rdat, output int lowc);
		int n;
		@(negedge mclk);
		cs_n = 1'b0;
		sel = cmd;
		rd_n = !rd;
		wr_n = rd;
		db_i = wd;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (ready === 1'b1 && n < 8);
		lowc = 0;
		while (ready !== 1'b1 && lowc < 20000) begin
			lowc++;
			@(posedge mclk);
		end
		rdat = db_o;
		@(negedge mclk);
		cs_n = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
		db_i = ~wd;
		repeat (gap) @(negedge mclk);
	endtask
	// Both acknowledge lines to one level
	task automatic set_ack(input logic v);
		@(negedge mclk);
		done_ack_n = v;
		svc_ack_n = v;
	endtask
endmodule
`default_nettype wire

// ==== tb/apu_status_and_command_timing_tb.sv ====
// Purpose: self-checking bench of the arithmetic unit host port
// Assumes: 40 MHz clock, inputs change on the falling edge
// Notes: a byte queue models the stack, tables give latencies
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Bench top
module apu_status_and_command_timing_tb;
	import apust_pkg::*;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic cs_n, sel, rd_n, wr_n, ack_n, sack_n, db_oe, ready, done_n, svc;
	logic [7:0] db_i, db_o, rd;
	logic [31:0] seed = 32'h000013a6;
	logic [7:0] q[$];
	int fail_count = 0, checked = 0, cyc = 0, lc, n, n0, x, k, t;
	// Clock and hang guard
	always #12.5 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 100000) begin
			fail_count++;
			results();
		end
	end
	// Design and host
	apust_core dut_u (.MCLK(mclk), .RST_N(rst_n), .CE(1'b1), .CS_N(cs_n), .CMD_DATA_SELECT(sel), .RD_N(rd_n),
		.WR_N(wr_n), .DB_I(db_i), .DB_O(db_o), .DB_OE(db_oe), .READY(ready), .EXEC_DONE_N(done_n),
		.EXEC_DONE_ACK_N(ack_n), .SERVICE_REQUEST(svc), .SERVICE_ACK_N(sack_n));
	apust_host host_u (.mclk(mclk), .ready(ready), .db_o(db_o), .cs_n(cs_n), .sel(sel), .rd_n(rd_n),
		.wr_n(wr_n), .db_i(db_i), .done_ack_n(ack_n), .svc_ack_n(sack_n));
	// Helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic cmp(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic results();
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] b, input int gap);
		host_u.xfer(1'b0, 1'b0, b, gap, rd, lc);
		q.push_back(b);
	endtask
	task automatic pop();
		host_u.xfer(1'b1, 1'b0, 8'h00, 6, rd, lc);
		cmp(16'(rd), 16'(q.pop_back()));
	endtask
	task automatic stat();
		host_u.xfer(1'b1, 1'b1, 8'h00, 6, rd, lc);
	endtask
	// Command write, then cycles from release to done
	task automatic run(input logic [7:0] c);
		host_u.xfer(1'b0, 1'b1, c, 0, rd, lc);
		n = 0;
		while (done_n !== 1'b0 && n < 13000) begin
			@(posedge mclk);
			n++;
		end
	endtask
	task automatic ack();
		host_u.set_ack(1'b0);
		@(negedge mclk);
		host_u.set_ack(1'b1);
		repeat (6) @(negedge mclk);
		cmp(16'(done_n), 16'h0001);
		cmp(16'(svc), 16'h0000);
	endtask
	task automatic err(input logic [5:0] c, input logic [7:0] hi, input logic [3:0] e);
		wr(8'h00, 6);
		wr(8'h00, 6);
		wr(hi == 8'h00 ? 8'h00 : 8'h80, 6);
		wr(hi, 6);
		run({2'b00, c});
		ack();
		stat();
		cmp(16'(rd[4:1]), 16'(e));
		cmp(16'(rd[7]), 16'h0000);
	endtask
	// Main sequence
	initial begin
		repeat (20) @(negedge mclk);
		rst_n = 1'b1;
		repeat (2) @(negedge mclk);
		// Back-to-back pushes, add, flags and result
		for (int i = 0; i < 4; i++) wr(8'(rnd()) & (i[0] ? 8'h3f : 8'hff), i == 3 ? 6 : 0);
		x = q.pop_back() << 8;
		x += q.pop_back();
		x += q.pop_back() << 8;
		x += q.pop_back();
		q.push_back(8'(x));
		q.push_back(8'(x >> 8));
		run({2'b00, CMD_FIX16_ADD});
		cmp(16'(lc), 16'h0001);
		ack();
		stat();
		cmp(16'(rd), 16'({1'b0, x[15], x[15:0] == 16'h0000, 5'h00}));
		cmp(16'(lc), 16'h0004);
		pop();
		cmp(16'(lc), 16'h0006);
		pop();
		wr(8'h5a, 6);
		cmp(16'(lc), 16'h0001);
		// Every command code against the table
		run({2'b00, CMD_NO_OPERATION});
		n0 = n;
		cmp(16'(n0 > 5 && n0 < 11), 16'h0001);
		ack();
		for (int c = 0; c < 43; c++) begin
			k = (c == 42) ? 29 : c;
			t = (c < 18) ? int'(rnd() & 32'h000000ff) : 0;
			wr(8'(t), 6);
			run(c == 42 ? 8'h3f : 8'(c));
			x = LAT_MIN[k] + (int'(LAT_MAX[k] - LAT_MIN[k]) * t) / 256;
			cmp(16'(n - n0), 16'(x - 4));
			ack();
		end
		// Reads while a service-enabled sine runs
		wr(8'h00, 6);
		host_u.xfer(1'b0, 1'b1, {2'b10, CMD_SINE_OP}, 0, rd, lc);
		stat();
		cmp(16'(rd), 16'h0080);
		cmp(16'(lc), 16'h0004);
		host_u.xfer(1'b1, 1'b0, 8'h00, 0, rd, lc);
		cmp(16'({done_n, svc, lc > 4000}), 16'h0003);
		ack();
		// Command entered while busy
		host_u.xfer(1'b0, 1'b1, {2'b00, CMD_SWAP_FIX16}, 0, rd, lc);
		host_u.xfer(1'b0, 1'b1, {2'b00, CMD_NO_OPERATION}, 0, rd, lc);
		cmp(16'({done_n, lc > 8}), 16'h0001);
		repeat (20) @(negedge mclk);
		ack();
		err(CMD_FIX16_DIV, 8'h00, ERR_DIV0);
		err(CMD_SQUARE_ROOT_OP, 8'hc1, ERR_NEG);
		err(CMD_ARCSINE_OP, 8'h02, ERR_ARG);
		// Acknowledge held low gives a fixed done pulse
		host_u.set_ack(1'b0);
		run({2'b00, CMD_NO_OPERATION});
		x = 0;
		while (done_n === 1'b0 && x < 50) begin
			@(posedge mclk);
			x++;
		end
		cmp(16'(x), 16'h0009);
		host_u.set_ack(1'b1);
		results();
	end
endmodule
`default_nettype wire
